// ### logic/rmad_pkg.sv
// Constants, commands, states and carriers of the radio MAC datapath
package rmad_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TB_HZ  = 250_000;
  localparam logic [7:0]  TB_DIV_LAST = 8'(CLK_HZ / TB_HZ - 1);
  localparam logic [4:0]  SLOT_LAST   = 5'h13;

  // ------------------------------------------------------------
  // Random generator and checksum
  // ------------------------------------------------------------
  localparam logic [31:0] LFSR_SEED = 32'h00000001;
  localparam logic [31:0] LFSR_TAPS = 32'h80200003;
  localparam logic [15:0] CRC_POLY  = 16'h8408;
  localparam logic [15:0] CRC_INIT  = 16'h0000;
  localparam logic [15:0] CRC_GOOD  = 16'h0000;

  // ------------------------------------------------------------
  // Frame layout
  // ------------------------------------------------------------
  localparam logic [7:0] PRE_BYTE = 8'h00;
  localparam logic [7:0] PRE_LEN  = 8'h04;
  localparam logic [7:0] SFD_BYTE = 8'ha7;
  localparam logic [7:0] HDR_LAST = 8'h05;
  localparam logic [7:0] FCS_LEN  = 8'h02;
  localparam logic [7:0] MIN_LEN  = 8'h02;
  localparam logic [7:0] SEQ_IDX  = 8'h02;

  // ------------------------------------------------------------
  // Event vector positions
  // ------------------------------------------------------------
  localparam int EV_N     = 7;
  localparam int EV_SOFT  = 0;
  localparam int EV_SYNC  = 1;
  localparam int EV_BEGIN = 2;
  localparam int EV_DONE  = 3;
  localparam int EV_CRC   = 4;
  localparam int EV_FLT   = 5;
  localparam int EV_LVL   = 6;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ACT_NONE, ACT_RX, ACT_TX, ACT_CCA, ACT_ED, ACT_IDLE
  } rmad_act_t;

  typedef enum logic [2:0] {
    MC_IDLE, MC_RX, MC_RESTART, MC_TX, MC_CCA, MC_ED
  } rmad_mcmd_t;

  typedef enum logic [2:0] {
    MS_IDLE, MS_RX, MS_TX, MS_CCA, MS_ED
  } rmad_mstate_t;

  typedef enum logic [3:0] {
    S_IDLE, S_SLOT, S_TX_HDR, S_TX_FETCH, S_TX_SEND, S_TX_FCS,
    S_RX_LEN, S_RX_BODY, S_RX_CHECK, S_MODEM_WAIT
  } rmad_seq_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } rmad_mem_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rmad_byte_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] idx;
    logic [7:0] data;
  } rmad_hdr_t;

  typedef struct packed {
    rmad_seq_t     st;
    rmad_act_t     act;
    logic          pend;
    logic [7:0]    div;
    logic [31:0]   tb;
    logic [4:0]    slot;
    logic [31:0]   lfsr;
    logic [31:0]   rx_ts;
    logic [31:0]   cpl_ts;
    logic [15:0]   crc;
    logic [7:0]    idx;
    logic [7:0]    len;
    logic [7:0]    rxcnt;
    logic [7:0]    buf_byte;
    logic [7:0]    seq;
    logic          busy_seen;
    rmad_mstate_t  ms1;
    rmad_mstate_t  ms2;
    rmad_mcmd_t    cmd;
    logic          cmd_stb;
    rmad_mem_t     mem;
    rmad_byte_t    tx;
    rmad_hdr_t     hdr;
    logic [EV_N-1:0] ev;
    logic [EV_N-1:0] status;
  } rmad_state_t;

  localparam rmad_state_t ST_RESET = '{
    st: S_IDLE, act: ACT_NONE, ms1: MS_IDLE, ms2: MS_IDLE, cmd: MC_IDLE,
    lfsr: LFSR_SEED, crc: CRC_INIT, default: '0
  };

endpackage

// ### logic/rmad_top.sv
// Sequencer, packet path, byte DMA, checksum, random and slot timing
`timescale 1ns/100ps
module rmad_top (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    ce,
  input  wire logic                    soft_rst,
  input  wire logic                    action_wr,
  input  wire rmad_pkg::rmad_act_t     action_cmd,
  input  wire logic                    start_armed,
  input  wire logic                    start_fire,
  input  wire logic                    soft_timer_fire,
  input  wire logic                    rnd_wr,
  input  wire logic [31:0]             rnd_wdata,
  output logic [31:0]                  rnd_value,
  input  wire logic [31:0]             tx_buffer_pointer,
  input  wire logic [31:0]             rx_buffer_pointer,
  input  wire logic [7:0]              tx_byte_length,
  input  wire logic [7:0]              rx_level_threshold,
  output logic [7:0]                   rx_byte_count,
  input  wire logic                    csma_slotted,
  input  wire logic                    use_slot_offset,
  input  wire logic [4:0]              slot_offset_preload,
  input  wire logic                    beacon_event,
  output rmad_pkg::rmad_mem_t          mem,
  input  wire logic [7:0]              mem_rdata,
  input  wire logic                    mem_ack,
  output logic                         bus_stall,
  output rmad_pkg::rmad_mcmd_t         modem_cmd,
  output logic                         modem_cmd_stb,
  input  wire rmad_pkg::rmad_mstate_t  modem_state,
  output rmad_pkg::rmad_byte_t         tx,
  input  wire logic                    tx_ready,
  input  wire logic                    rx_valid,
  input  wire logic [7:0]              rx_byte,
  output rmad_pkg::rmad_hdr_t          hdr,
  input  wire logic                    filter_reject,
  output logic [7:0]                   seq_number,
  output logic [rmad_pkg::EV_N-1:0]    events,
  output logic [rmad_pkg::EV_N-1:0]    event_status,
  input  wire logic [rmad_pkg::EV_N-1:0] event_clear,
  input  wire logic [rmad_pkg::EV_N-1:0] event_mask,
  output logic                         irq,
  output logic [31:0]                  rx_sync_timestamp,
  output logic [31:0]                  completion_timestamp,
  output logic [31:0]                  timebase
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    lfsr_step = (v >> 1) ^ (v[0] ? rmad_pkg::LFSR_TAPS : 32'h0);
  endfunction

  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] x;
    x = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      x = (x >> 1) ^ (x[0] ? rmad_pkg::CRC_POLY : 16'h0);
    end
    crc_byte = x;
  endfunction

  rmad_pkg::rmad_state_t   r;
  rmad_pkg::rmad_state_t   n;
  logic [rmad_pkg::EV_N-1:0] new_ev;
  logic                    tick;
  logic                    slot_edge;
  logic                    tx_free;
  logic                    done;
  logic                    restart;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    n = r;
    new_ev = '0;
    done = 1'b0;
    restart = 1'b0;
    n.ms1 = modem_state;
    n.ms2 = r.ms1;
    n.cmd_stb = 1'b0;
    n.hdr.valid = 1'b0;

    tick = (r.div == rmad_pkg::TB_DIV_LAST);
    n.div = tick ? 8'h00 : r.div + 8'h01;
    if (tick) begin
      n.tb = r.tb + 32'h1;
    end
    slot_edge = tick && (r.slot == rmad_pkg::SLOT_LAST);
    if (beacon_event) begin
      n.slot = use_slot_offset ? slot_offset_preload : 5'h00;
    end else if (tick) begin
      n.slot = slot_edge ? 5'h00 : r.slot + 5'h01;
    end

    n.lfsr = rnd_wr ? rnd_wdata : lfsr_step(r.lfsr);

    if (r.mem.req && mem_ack) begin
      n.mem.req = 1'b0;
    end
    tx_free = !r.tx.valid || tx_ready;
    if (r.tx.valid && tx_ready) begin
      n.tx.valid = 1'b0;
    end

    if (soft_timer_fire) begin
      new_ev[rmad_pkg::EV_SOFT] = 1'b1;
    end

    unique case (r.st)
      rmad_pkg::S_IDLE: begin
        if (start_fire && !r.pend) begin
          done = 1'b1;
        end else if (r.pend && (start_fire || !start_armed)) begin
          new_ev[rmad_pkg::EV_BEGIN] = start_fire;
          n.pend = 1'b0;
          n.cmd_stb = 1'b1;
          n.idx = 8'h00;
          n.crc = rmad_pkg::CRC_INIT;
          n.busy_seen = 1'b0;
          unique case (r.act)
            rmad_pkg::ACT_TX: begin
              n.cmd = rmad_pkg::MC_TX;
              n.len = tx_byte_length;
              n.st = csma_slotted ? rmad_pkg::S_SLOT : rmad_pkg::S_TX_HDR;
            end
            rmad_pkg::ACT_RX: begin
              n.cmd = rmad_pkg::MC_RX;
              n.st = rmad_pkg::S_RX_LEN;
            end
            rmad_pkg::ACT_CCA: begin
              n.cmd = rmad_pkg::MC_CCA;
              n.st = rmad_pkg::S_MODEM_WAIT;
            end
            rmad_pkg::ACT_ED: begin
              n.cmd = rmad_pkg::MC_ED;
              n.st = rmad_pkg::S_MODEM_WAIT;
            end
            default: begin
              n.cmd = rmad_pkg::MC_IDLE;
              done = 1'b1;
            end
          endcase
        end
      end
      rmad_pkg::S_SLOT: begin
        if (slot_edge) begin
          n.st = rmad_pkg::S_TX_HDR;
        end
      end
      rmad_pkg::S_TX_HDR: begin
        if (tx_free) begin
          n.tx.valid = 1'b1;
          n.tx.data = (r.idx < rmad_pkg::PRE_LEN) ? rmad_pkg::PRE_BYTE :
                      (r.idx == rmad_pkg::PRE_LEN) ? rmad_pkg::SFD_BYTE : r.len;
          n.idx = r.idx + 8'h01;
          if (r.idx == rmad_pkg::HDR_LAST) begin
            n.idx = 8'h00;
            n.st = (r.len > rmad_pkg::FCS_LEN) ? rmad_pkg::S_TX_FETCH
                                                : rmad_pkg::S_TX_FCS;
          end
        end
      end
      rmad_pkg::S_TX_FETCH: begin
        if (!r.mem.req) begin
          n.mem.req = 1'b1;
          n.mem.we = 1'b0;
          n.mem.addr = tx_buffer_pointer + {24'h0, r.idx};
        end else if (mem_ack) begin
          n.buf_byte = mem_rdata;
          n.st = rmad_pkg::S_TX_SEND;
        end
      end
      rmad_pkg::S_TX_SEND: begin
        if (tx_free) begin
          n.tx.valid = 1'b1;
          n.tx.data = r.buf_byte;
          n.crc = crc_byte(r.crc, r.buf_byte);
          n.idx = r.idx + 8'h01;
          if (r.idx + 8'h01 == r.len - rmad_pkg::FCS_LEN) begin
            n.idx = 8'h00;
            n.st = rmad_pkg::S_TX_FCS;
          end else begin
            n.st = rmad_pkg::S_TX_FETCH;
          end
        end
      end
      rmad_pkg::S_TX_FCS: begin
        if (r.idx == rmad_pkg::FCS_LEN) begin
          if (!r.tx.valid) begin
            done = 1'b1;
          end
        end else if (tx_free) begin
          n.tx.valid = 1'b1;
          n.tx.data = r.idx[0] ? r.crc[15:8] : r.crc[7:0];
          n.idx = r.idx + 8'h01;
        end
      end
      rmad_pkg::S_RX_LEN: begin
        if (rx_valid) begin
          n.len = rx_byte;
          n.idx = 8'h00;
          n.rxcnt = 8'h00;
          n.crc = rmad_pkg::CRC_INIT;
          if (rx_byte < rmad_pkg::MIN_LEN) begin
            restart = 1'b1;
          end else begin
            new_ev[rmad_pkg::EV_SYNC] = 1'b1;
            n.rx_ts = r.tb;
            n.st = rmad_pkg::S_RX_BODY;
          end
        end
      end
      rmad_pkg::S_RX_BODY: begin
        if (filter_reject) begin
          new_ev[rmad_pkg::EV_FLT] = 1'b1;
          restart = 1'b1;
        end else if (rx_valid) begin
          n.mem.req = 1'b1;
          n.mem.we = 1'b1;
          n.mem.addr = rx_buffer_pointer + {24'h0, r.idx};
          n.mem.wdata = rx_byte;
          n.crc = crc_byte(r.crc, rx_byte);
          n.hdr.valid = 1'b1;
          n.hdr.idx = r.idx;
          n.hdr.data = rx_byte;
          if (r.idx == rmad_pkg::SEQ_IDX) begin
            n.seq = rx_byte;
          end
          n.idx = r.idx + 8'h01;
          n.rxcnt = r.rxcnt + 8'h01;
          if (r.idx + 8'h01 == r.len) begin
            n.st = rmad_pkg::S_RX_CHECK;
          end
        end
      end
      rmad_pkg::S_RX_CHECK: begin
        if (!r.mem.req) begin
          if (r.crc == rmad_pkg::CRC_GOOD) begin
            done = 1'b1;
          end else begin
            new_ev[rmad_pkg::EV_CRC] = 1'b1;
            restart = 1'b1;
          end
        end
      end
      rmad_pkg::S_MODEM_WAIT: begin
        if (r.ms2 != rmad_pkg::MS_IDLE) begin
          n.busy_seen = 1'b1;
        end else if (r.busy_seen) begin
          done = 1'b1;
        end
      end
      default: begin
        done = 1'b1;
      end
    endcase

    // Fast restart skips modem warm-up and keeps the action alive
    if (restart) begin
      n.st = rmad_pkg::S_RX_LEN;
      n.cmd = rmad_pkg::MC_RESTART;
      n.cmd_stb = 1'b1;
    end
    if (done) begin
      new_ev[rmad_pkg::EV_DONE] = 1'b1;
      n.cpl_ts = r.tb;
      n.st = rmad_pkg::S_IDLE;
      if (r.cmd != rmad_pkg::MC_IDLE) begin
        n.cmd = rmad_pkg::MC_IDLE;
        n.cmd_stb = 1'b1;
      end
    end
    // Written after dispatch so a write in the start cycle is kept
    if (action_wr) begin
      n.act = action_cmd;
      n.pend = 1'b1;
    end

    // Zero threshold disables the level source
    new_ev[rmad_pkg::EV_LVL] = (rx_level_threshold != 8'h00) &&
                               (r.rxcnt >= rx_level_threshold);
    n.ev = new_ev;
    // Set beats clear in the same cycle
    n.status = (r.status & ~event_clear) | new_ev;

    if (soft_rst) begin
      n = rmad_pkg::ST_RESET;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= rmad_pkg::ST_RESET;
    end else if (ce) begin
      r <= n;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign rnd_value = r.lfsr;
  assign rx_byte_count = r.rxcnt;
  assign mem = r.mem;
  assign bus_stall = r.mem.req;
  assign modem_cmd = r.cmd;
  assign modem_cmd_stb = r.cmd_stb;
  assign tx = r.tx;
  assign hdr = r.hdr;
  assign seq_number = r.seq;
  assign events = r.ev;
  assign event_status = r.status;
  assign irq = |(r.status & event_mask);
  assign rx_sync_timestamp = r.rx_ts;
  assign completion_timestamp = r.cpl_ts;
  assign timebase = r.tb;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_sync_ts;
    r.ev[rmad_pkg::EV_SYNC] |-> r.rx_ts == $past(r.tb) && r.st == rmad_pkg::S_RX_BODY;
  endproperty
  a_sync_ts: assert property (p_sync_ts) else $error("sync stamp wrong");

  property p_done_idle;
    $rose(r.ev[rmad_pkg::EV_DONE]) |-> r.st == rmad_pkg::S_IDLE && r.cpl_ts == $past(r.tb);
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("done not idle");

  property p_begin;
    ce && !soft_rst && r.st == rmad_pkg::S_IDLE && start_fire && r.pend
      |=> r.ev[rmad_pkg::EV_BEGIN] && !r.ev[rmad_pkg::EV_DONE];
  endproperty
  a_begin: assert property (p_begin) else $error("no begin event");

  property p_late;
    ce && !soft_rst && r.st == rmad_pkg::S_IDLE && start_fire && !r.pend
      |=> r.ev[rmad_pkg::EV_DONE] && !r.ev[rmad_pkg::EV_BEGIN];
  endproperty
  a_late: assert property (p_late) else $error("late start missed");

  property p_lfsr_run;
    ce && !rnd_wr && !soft_rst |=> r.lfsr == lfsr_step($past(r.lfsr));
  endproperty
  a_lfsr_run: assert property (p_lfsr_run) else $error("lfsr stalled");

  property p_seed;
    ce && rnd_wr && !soft_rst |=> r.lfsr == $past(rnd_wdata);
  endproperty
  a_seed: assert property (p_seed) else $error("seed not loaded");

  property p_soft_rst;
    ce && soft_rst |=> r.lfsr == rmad_pkg::LFSR_SEED && r.st == rmad_pkg::S_IDLE;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset lfsr");

  property p_dma_hold;
    r.mem.req && !mem_ack && !soft_rst |=> r.mem.req && $stable(r.mem.addr);
  endproperty
  a_dma_hold: assert property (p_dma_hold) else $error("dma dropped");

  property p_crc_restart;
    r.ev[rmad_pkg::EV_CRC] |-> r.st == rmad_pkg::S_RX_LEN && r.cmd == rmad_pkg::MC_RESTART;
  endproperty
  a_crc_restart: assert property (p_crc_restart) else $error("no restart");

  property p_set_wins;
    ce && !soft_rst && |new_ev |=> (r.status & $past(new_ev)) == $past(new_ev);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");

  property p_slot_start;
    ce && !soft_rst && r.st == rmad_pkg::S_SLOT ##1 r.st == rmad_pkg::S_TX_HDR
      |-> r.slot == 5'h00;
  endproperty
  a_slot_start: assert property (p_slot_start) else $error("off slot");

  c_tx_done: cover property (r.st == rmad_pkg::S_TX_FCS ##1 r.ev[rmad_pkg::EV_DONE]);
  c_rx_sync: cover property (r.ev[rmad_pkg::EV_SYNC]);
  c_crc_err: cover property (r.ev[rmad_pkg::EV_CRC]);
  c_reject: cover property (r.ev[rmad_pkg::EV_FLT]);

endmodule

// ### dv/rmad_far_model.sv
// RAM and RF modem model on the far side of the datapath
`timescale 1ns/100ps
module rmad_far_model (
  input  wire logic                 clk,
  input  wire rmad_pkg::rmad_mem_t  mem,
  output logic [7:0]                mem_rdata,
  output logic                      mem_ack,
  input  wire rmad_pkg::rmad_mcmd_t modem_cmd,
  input  wire logic                 modem_cmd_stb,
  output rmad_pkg::rmad_mstate_t    modem_state,
  input  wire rmad_pkg::rmad_byte_t tx,
  output logic                      tx_ready
);
  logic [7:0] ram [0:255];
  logic [7:0] txq [$];
  logic [2:0] busy;
  logic [3:0] cnt;
  initial begin
    {mem_ack, tx_ready, busy, cnt} = '0;
    mem_rdata = 8'h00;
    modem_state = rmad_pkg::MS_IDLE;
  end
  // ------------------------------------------------------------
  // Acks alternate prompt and late; stale read data is inverted
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cnt <= cnt + 4'h1;
    mem_ack <= mem.req && !mem_ack && cnt[0];
    mem_rdata <= (mem.req && !mem_ack) ? ram[mem.addr[7:0]] : ~mem_rdata;
    if (mem_ack && mem.we) begin
      ram[mem.addr[7:0]] <= mem.wdata;
    end
    tx_ready <= cnt[1];
    if (tx.valid && tx_ready) begin
      txq.push_back(tx.data);
    end
    if (modem_cmd_stb) begin
      busy <= 3'h4;
      case (modem_cmd)
        rmad_pkg::MC_CCA:  modem_state <= rmad_pkg::MS_CCA;
        rmad_pkg::MC_ED:   modem_state <= rmad_pkg::MS_ED;
        rmad_pkg::MC_TX:   modem_state <= rmad_pkg::MS_TX;
        rmad_pkg::MC_IDLE: modem_state <= rmad_pkg::MS_IDLE;
        default:           modem_state <= rmad_pkg::MS_RX;
      endcase
    end else if (busy != 3'h0) begin
      busy <= busy - 3'h1;
      if (busy == 3'h1 && modem_state inside {rmad_pkg::MS_CCA, rmad_pkg::MS_ED}) begin
        modem_state <= rmad_pkg::MS_IDLE;
      end
    end
  end
endmodule

// ### dv/rmad_tb_top.sv
// Self-checking bench for the radio MAC datapath
`timescale 1ns/100ps
module rmad_tb_top;
  logic        clk, rst, ce, soft_rst, action_wr, start_armed, start_fire, soft_timer_fire;
  logic        rnd_wr, csma_slotted, use_slot_offset, beacon_event, mem_ack, modem_cmd_stb;
  logic        tx_ready, rx_valid, filter_reject, bus_stall, irq;
  logic [31:0] rnd_wdata, rnd_value, tx_buffer_pointer, rx_buffer_pointer;
  logic [31:0] rx_sync_timestamp, completion_timestamp, timebase;
  logic [7:0]  tx_byte_length, rx_level_threshold, rx_byte_count, mem_rdata, rx_byte;
  logic [7:0]  seq_number;
  logic [4:0]  slot_offset_preload;
  logic [rmad_pkg::EV_N-1:0] events, event_status, event_clear, event_mask;
  rmad_pkg::rmad_act_t    action_cmd;
  rmad_pkg::rmad_mem_t    mem;
  rmad_pkg::rmad_mcmd_t   modem_cmd;
  rmad_pkg::rmad_mstate_t modem_state;
  rmad_pkg::rmad_byte_t   tx;
  rmad_pkg::rmad_hdr_t    hdr;
  logic [7:0]  body [5] = '{8'h41, 8'h88, 8'h3c, 8'h00, 8'h00};
  int          miscompares = 0;
  int          tests_run = 0;
  int          n;

  rmad_top dut (.clk, .rst, .ce, .soft_rst, .action_wr, .action_cmd, .start_armed, .start_fire,
    .soft_timer_fire, .rnd_wr, .rnd_wdata, .rnd_value, .tx_buffer_pointer, .rx_buffer_pointer,
    .tx_byte_length, .rx_level_threshold, .rx_byte_count, .csma_slotted, .use_slot_offset,
    .slot_offset_preload, .beacon_event, .mem, .mem_rdata, .mem_ack, .bus_stall, .modem_cmd,
    .modem_cmd_stb, .modem_state, .tx, .tx_ready, .rx_valid, .rx_byte, .hdr, .filter_reject,
    .seq_number, .events, .event_status, .event_clear, .event_mask, .irq, .rx_sync_timestamp,
    .completion_timestamp, .timebase);
  rmad_far_model far (.clk, .mem, .mem_rdata, .mem_ack, .modem_cmd, .modem_cmd_stb,
    .modem_state, .tx, .tx_ready);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic close_out();
    if (miscompares == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic wait_ev(input int b, input int lim);
    int i;
    for (i = 0; i < lim && events[b] !== 1'b1; i++) @(negedge clk);
    if (i == lim) begin
      check(32'h0, 32'h1, "event wait timed out");
      close_out();
    end
  endtask
  task automatic wait_cmd(input rmad_pkg::rmad_mcmd_t c, output int k);
    for (k = 0; k < 1000 && !(modem_cmd_stb === 1'b1 && modem_cmd === c); k++) @(negedge clk);
    if (k == 1000) begin
      check(32'h0, 32'h1, "modem command wait timed out");
      close_out();
    end
  endtask
  task automatic clear_all();
    event_clear = '1;
    @(negedge clk);
    event_clear = '0;
  endtask
  function automatic logic [31:0] step(input logic [31:0] v);
    return v[0] ? (v >> 1) ^ rmad_pkg::LFSR_TAPS : v >> 1;
  endfunction
  function automatic logic [15:0] crc_b(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ rmad_pkg::CRC_POLY : c >> 1;
    return c;
  endfunction
  function automatic logic stamp_ok(input logic [31:0] s);
    return s === timebase || s === timebase - 32'h1;
  endfunction

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_lfsr();
    logic [31:0] v;
    v = rnd_value;
    @(negedge clk);
    check(rnd_value, step(v), "lfsr step");
    v = rnd_value;
    ce = 1'b0;
    repeat (3) @(negedge clk);
    check(rnd_value, v, "frozen lfsr");
    ce = 1'b1;
    rnd_wdata = 32'hc0de5eed;
    pulse(rnd_wr);
    check(rnd_value, 32'hc0de5eed, "seed write");
    pulse(soft_rst);
    check(rnd_value, 32'h1, "soft reset seed");
  endtask
  task automatic t_events();
    pulse(soft_timer_fire);
    check(events[rmad_pkg::EV_SOFT], 1'b1, "soft timeout");
    @(negedge clk);
    check(events[rmad_pkg::EV_SOFT], 1'b0, "soft pulse length");
    check(irq, 1'b1, "irq raised");
    event_mask = '0;
    #1 check(irq, 1'b0, "irq masked");
    event_mask = '1;
    clear_all();
    check(event_status, '0, "status cleared");
  endtask
  task automatic t_start();
    start_armed = 1'b1;
    pulse(start_fire);
    check(events[rmad_pkg::EV_DONE], 1'b1, "fire with nothing pending");
    check(events[rmad_pkg::EV_BEGIN], 1'b0, "no begin");
    action_cmd = rmad_pkg::ACT_CCA;
    pulse(action_wr);
    repeat (3) @(negedge clk);
    check(modem_cmd_stb, 1'b0, "armed action waits");
    pulse(start_fire);
    check(events[rmad_pkg::EV_BEGIN], 1'b1, "action begins");
    wait_ev(rmad_pkg::EV_DONE, 60);
    check(stamp_ok(completion_timestamp), 1'b1, "completion stamp");
    start_armed = 1'b0;
    for (int k = 0; k < 2; k++) begin
      action_cmd = k ? rmad_pkg::ACT_ED : rmad_pkg::ACT_CCA;
      pulse(action_wr);
      wait_cmd(k ? rmad_pkg::MC_ED : rmad_pkg::MC_CCA, n);
      wait_ev(rmad_pkg::EV_DONE, 60);
      check(modem_cmd, rmad_pkg::MC_IDLE, "modem back to idle");
    end
    action_cmd = rmad_pkg::ACT_IDLE;
    pulse(action_wr);
    wait_ev(rmad_pkg::EV_DONE, 3);
    check(modem_cmd, rmad_pkg::MC_IDLE, "force idle");
  endtask
  task automatic t_tx();
    logic [7:0]  exp [$];
    logic [15:0] c;
    c = rmad_pkg::CRC_INIT;
    exp = '{8'h00, 8'h00, 8'h00, 8'h00, rmad_pkg::SFD_BYTE, 8'h05};
    far.txq.delete();
    for (int i = 0; i < 3; i++) begin
      far.ram[8'h10 + i] = body[i];
      exp.push_back(body[i]);
      c = crc_b(c, body[i]);
    end
    {body[4], body[3]} = c;
    exp.push_back(c[7:0]);
    exp.push_back(c[15:8]);
    action_cmd = rmad_pkg::ACT_TX;
    pulse(action_wr);
    wait_ev(rmad_pkg::EV_DONE, 400);
    check(far.txq.size(), 11, "frame length");
    foreach (exp[i]) check(far.txq[i], exp[i], "tx byte");
  endtask
  task automatic rxb(input logic [7:0] b);
    rx_valid = 1'b1;
    rx_byte = b;
    @(negedge clk);
    rx_valid = 1'b0;
    rx_byte = ~b;
  endtask
  task automatic frame(input logic [7:0] flip, input logic rej);
    logic [7:0] b;
    clear_all();
    rxb(8'h05);
    wait_ev(rmad_pkg::EV_SYNC, 3);
    check(stamp_ok(rx_sync_timestamp), 1'b1, "sync stamp");
    for (int i = 0; i < (rej ? 1 : 5); i++) begin
      b = (i == 4) ? body[i] ^ flip : body[i];
      // Idle cycle keeps rx_valid from being raised in the step that lowered it
      @(negedge clk);
      filter_reject = rej;
      rxb(b);
      filter_reject = 1'b0;
      if (!rej) check(bus_stall, 1'b1, "dma stall");
      if (!rej) check({hdr.valid, hdr.idx, hdr.data}, {1'b1, 8'(i), b}, "header feed");
      repeat (7) @(negedge clk);
      if (!rej) check(rx_byte_count, i + 1, "byte count");
      if (i == 1 || i == 2) check(events[rmad_pkg::EV_LVL], i == 2, "rx level");
    end
  endtask
  task automatic t_rx();
    action_cmd = rmad_pkg::ACT_RX;
    pulse(action_wr);
    wait_cmd(rmad_pkg::MC_RX, n);
    frame(8'h01, 1'b0);
    check(event_status[rmad_pkg::EV_CRC], 1'b1, "checksum error");
    check(modem_cmd, rmad_pkg::MC_RESTART, "receiver restart");
    frame(8'h00, 1'b1);
    check(event_status[rmad_pkg::EV_FLT], 1'b1, "header reject");
    frame(8'h00, 1'b0);
    check(event_status[rmad_pkg::EV_DONE], 1'b1, "good frame done");
    for (int i = 0; i < 5; i++) check(far.ram[8'h80 + i], body[i], "rx ram");
    check(seq_number, body[2], "sequence number");
  endtask
  task automatic t_slot();
    logic [31:0] t0;
    csma_slotted = 1'b1;
    action_cmd = rmad_pkg::ACT_TX;
    for (int k = 1; k >= 0; k--) begin
      use_slot_offset = k[0];
      // Align to a fresh symbol tick so the slot edge lands at a known cycle
      t0 = timebase;
      for (n = 0; n < 50 && timebase === t0; n++) @(negedge clk);
      check(n < 50, 1'b1, "timebase runs");
      {beacon_event, action_wr} = 2'b11;
      @(negedge clk);
      {beacon_event, action_wr} = 2'b00;
      for (n = 0; n < 900 && tx.valid !== 1'b1; n++) @(negedge clk);
      check(k ? n < 45 : n > 700 && n < 900, 1'b1, "slot aligned start");
      wait_ev(rmad_pkg::EV_DONE, 400);
    end
  endtask

  initial begin
    {rst, ce} = 2'b11;
    {soft_rst, action_wr, start_armed, start_fire, soft_timer_fire, rnd_wr} = '0;
    {csma_slotted, use_slot_offset, beacon_event, rx_valid, filter_reject} = '0;
    {rnd_wdata, rx_byte, event_clear} = '0;
    tx_buffer_pointer = 32'h10;
    rx_buffer_pointer = 32'h80;
    tx_byte_length = 8'h05;
    rx_level_threshold = 8'h03;
    slot_offset_preload = 5'h13;
    event_mask = '1;
    action_cmd = rmad_pkg::ACT_NONE;
    repeat (2) @(negedge clk);
    check(rnd_value, 32'h1, "seed at reset");
    rst = 1'b0;
    t_lfsr();
    t_events();
    t_start();
    t_tx();
    t_rx();
    t_slot();
    close_out();
  end
endmodule
